// file: verilog/batch_privilege_filter_pkg.sv
package batch_privilege_filter_pkg;

   // Command kinds presented by the parser front end
   typedef enum logic [4:0] {
      CMD_OTHER,
      CMD_NOOP,
      CMD_TRANSLATION_TABLE_UPDATE,
      CMD_STORE_IMMEDIATE,
      CMD_STORE_BY_INDEX,
      CMD_STORE_REG_TO_MEMORY,
      CMD_BATCH_START,
      CMD_LOAD_REG_IMMEDIATE,
      CMD_LOAD_REG_FROM_MEMORY,
      CMD_LOAD_REG_FROM_REG,
      CMD_PERF_COUNT_REPORT,
      CMD_PIPE_CONTROL,
      CMD_CONTEXT_SET,
      CMD_ATOMIC_MEMORY,
      CMD_MEMORY_COPY,
      CMD_SEMAPHORE_WAIT,
      CMD_ARBITRATION_TOGGLE,
      CMD_DISPLAY_FLIP,
      CMD_CONDITIONAL_BATCH_END,
      CMD_REG_READ
   } cmd_kind_type;

   // Streamer selection
   typedef enum logic [1:0] {
      STREAMER_RENDER,
      STREAMER_BLITTER,
      STREAMER_COMPUTE_ZERO
   } streamer_type;

   // Streamer register bases
   localparam logic [23:0] RENDER_BASE       = 24'h002000;
   localparam logic [23:0] BLITTER_BASE      = 24'h022000;
   localparam logic [23:0] COMPUTE_ZERO_BASE = 24'h01A000;

   // Allow-list depth and window
   localparam int          LIST_DEPTH = 8;
   localparam logic [23:0] WINDOW_MASK = 24'h000FFF;

   // APB register byte offsets
   localparam logic [11:0] OFS_CONTROL     = 12'h000;
   localparam logic [11:0] OFS_ERR_STATUS  = 12'h004;
   localparam logic [11:0] OFS_ERR_MASK    = 12'h008;
   localparam logic [11:0] OFS_ERR_IDENT   = 12'h00C;
   localparam logic [11:0] OFS_WLIST_BASE  = 12'h040;
   localparam logic [11:0] OFS_RLIST_BASE  = 12'h080;

   // Control bit positions
   localparam int CTRL_CHECK_DISABLE = 0;
   localparam int CTRL_STREAMER_LO   = 1;

   // Status bit positions
   localparam int STAT_VIOLATION = 0;
   localparam int STAT_COND_END  = 1;

   // Reset values
   localparam logic [31:0] CONTROL_RESET = 32'h00000000;
   localparam logic [1:0]  MASK_RESET    = 2'h0;
   localparam logic [23:0] LIST_RESET    = 24'hFFFFFF;

endpackage

// file: verilog/batch_privilege_filter.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - Buffer in global translation space is privileged; per-process space is not.
// - Privileged command in non-privileged buffer flags violation and is dropped or has its privileged write suppressed.
// - Violation logged in identity register and raised as an interrupt.
// - Check-disable bit skips every privilege check.
// - Table update, store-by-index, arbitration, flip always become no-ops; context set too unless blitter is selected.
// - Store-immediate, load-from-memory, perf report, atomic, semaphore: no-op if global.
// - Store-register-to-memory reads register; memory write dropped if global.
// - Batch start target privilege never exceeds its parent's.
// - Immediate and memory register loads to privileged registers become no-ops.
// - Register-to-register write to privileged register is discarded.
// - Pipe control flushes; post-sync no-op if global or store-index selected.
// - Pipe control post-sync immediate load to privileged register is discarded.
// - Memory copy becomes no-op if source or destination is global.
// - Reads allowed only at read-list or write-list offsets.
// - Listed offsets resolve relative to the selected streamer's base.
// - Conditional batch end with global selection becomes no-op and flags error.
module batch_privilege_filter
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        cmdValid,
   input  wire logic [4:0]  cmdKind,
   input  wire logic        bufferGlobal,
   input  wire logic        inRing,
   input  wire logic        selGlobal,
   input  wire logic        selGlobalDst,
   input  wire logic        useStoreIndex,
   input  wire logic        postSyncLoad,
   input  wire logic [23:0] regAddr,
   input  wire logic [23:0] regAddrDst,
   output logic             outValid,
   output logic [4:0]       outKind,
   output logic             outMemWrite,
   output logic             outRegWrite,
   output logic             outPostSync,
   output logic             outFlush,
   output logic             curPrivileged,
   output logic             irq
);

   logic [31:0] control_q;
   logic [1:0]  errStatus_q;
   logic [1:0]  errMask_q;
   logic [31:0] errIdent_q;
   logic [23:0] writeList_q [batch_privilege_filter_pkg::LIST_DEPTH];
   logic [23:0] readList_q  [batch_privilege_filter_pkg::LIST_DEPTH];
   logic        parentPriv_q;
   logic        secondLevel_q;
   logic        checkDisable;
   logic [1:0]  streamerSel;
   logic [23:0] streamerBase;
   logic        apbWrite;
   logic        privNow;
   logic        srcRegPriv;
   logic        dstRegPriv;
   logic        readAllowed;
   logic        dropCmd;
   logic        memWr;
   logic        regWr;
   logic        postSync;
   logic        violation;
   logic        condEndErr;
   logic        childPriv;
   logic [1:0]  errSet;

   assign checkDisable = control_q[batch_privilege_filter_pkg::CTRL_CHECK_DISABLE];
   assign streamerSel  = control_q[batch_privilege_filter_pkg::CTRL_STREAMER_LO +: 2];
   assign apbWrite     = psel && penable && pwrite && clkEn;

   // Base of the selected streamer
   always_comb
   begin
      case (streamerSel)
         2'h1:    streamerBase = batch_privilege_filter_pkg::BLITTER_BASE;
         2'h2:    streamerBase = batch_privilege_filter_pkg::COMPUTE_ZERO_BASE;
         default: streamerBase = batch_privilege_filter_pkg::RENDER_BASE;
      endcase
   end

   // Offset of an absolute register address within the streamer window
   function automatic logic [23:0] relOffset(input logic [23:0] addr, input logic [23:0] base);
      relOffset = addr - base;
   endfunction

   // Search of an allow-list for an offset
   function automatic logic listHit(input logic [23:0] ofs,
                                    input logic [23:0] list [batch_privilege_filter_pkg::LIST_DEPTH]);
      listHit = 1'b0;
      for (int i = 0; i < batch_privilege_filter_pkg::LIST_DEPTH; i++)
      begin
         if (list[i] == ofs)
         begin
            listHit = 1'b1;
         end
      end
   endfunction

   // Register privilege: anything absent from the write list
   assign srcRegPriv  = !listHit(relOffset(regAddr, streamerBase), writeList_q);
   assign dstRegPriv  = !listHit(relOffset(regAddrDst, streamerBase), writeList_q);
   assign readAllowed = !srcRegPriv ||
                        listHit(relOffset(regAddr, streamerBase), readList_q);

   // Effective privilege of the running buffer
   assign privNow = inRing || (bufferGlobal && (!secondLevel_q || parentPriv_q));

   // Filter decision for the current command
   always_comb
   begin
      dropCmd    = 1'b0;
      memWr      = 1'b1;
      regWr      = 1'b1;
      postSync   = postSyncLoad;
      violation  = 1'b0;
      condEndErr = 1'b0;
      if (!privNow && !checkDisable)
      begin
         case (batch_privilege_filter_pkg::cmd_kind_type'(cmdKind))
            batch_privilege_filter_pkg::CMD_TRANSLATION_TABLE_UPDATE,
            batch_privilege_filter_pkg::CMD_STORE_BY_INDEX,
            batch_privilege_filter_pkg::CMD_ARBITRATION_TOGGLE,
            batch_privilege_filter_pkg::CMD_DISPLAY_FLIP:
            begin
               dropCmd   = 1'b1;
               violation = 1'b1;
            end
            batch_privilege_filter_pkg::CMD_CONTEXT_SET:
            begin
               if (streamerSel != 2'h1)
               begin
                  dropCmd   = 1'b1;
                  violation = 1'b1;
               end
            end
            batch_privilege_filter_pkg::CMD_STORE_IMMEDIATE,
            batch_privilege_filter_pkg::CMD_PERF_COUNT_REPORT,
            batch_privilege_filter_pkg::CMD_ATOMIC_MEMORY,
            batch_privilege_filter_pkg::CMD_SEMAPHORE_WAIT:
            begin
               dropCmd   = selGlobal;
               violation = selGlobal;
            end
            batch_privilege_filter_pkg::CMD_LOAD_REG_FROM_MEMORY:
            begin
               dropCmd   = selGlobal || srcRegPriv;
               violation = dropCmd;
            end
            batch_privilege_filter_pkg::CMD_LOAD_REG_IMMEDIATE:
            begin
               dropCmd   = srcRegPriv;
               violation = srcRegPriv;
            end
            batch_privilege_filter_pkg::CMD_STORE_REG_TO_MEMORY:
            begin
               memWr     = !selGlobal;
               violation = selGlobal;
            end
            batch_privilege_filter_pkg::CMD_LOAD_REG_FROM_REG:
            begin
               regWr     = !dstRegPriv;
               violation = dstRegPriv;
            end
            batch_privilege_filter_pkg::CMD_PIPE_CONTROL:
            begin
               if (selGlobal || useStoreIndex)
               begin
                  postSync  = 1'b0;
                  violation = 1'b1;
               end
               else if (postSyncLoad && srcRegPriv)
               begin
                  postSync  = 1'b0;
                  violation = 1'b1;
               end
            end
            batch_privilege_filter_pkg::CMD_MEMORY_COPY:
            begin
               dropCmd   = selGlobal || selGlobalDst;
               violation = dropCmd;
            end
            batch_privilege_filter_pkg::CMD_CONDITIONAL_BATCH_END:
            begin
               dropCmd    = selGlobal;
               condEndErr = selGlobal;
            end
            batch_privilege_filter_pkg::CMD_REG_READ:
            begin
               dropCmd   = !readAllowed;
               violation = !readAllowed;
            end
            default:
            begin
               dropCmd = 1'b0;
            end
         endcase
      end
   end

   // Child buffer privilege is capped by the parent's
   assign childPriv = privNow && bufferGlobal;
   // Batch nesting state
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         parentPriv_q  <= 1'b1;
         secondLevel_q <= 1'b0;
      end
      else if (clkEn && cmdValid &&
               cmdKind == 5'(batch_privilege_filter_pkg::CMD_BATCH_START))
      begin
         parentPriv_q  <= childPriv;
         secondLevel_q <= !inRing;
      end
      else if (clkEn && cmdValid && inRing)
      begin
         parentPriv_q  <= 1'b1;
         secondLevel_q <= 1'b0;
      end
   end

   // Filtered command output stage
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         outValid      <= 1'b0;
         outKind       <= 5'h00;
         outMemWrite   <= 1'b0;
         outRegWrite   <= 1'b0;
         outPostSync   <= 1'b0;
         outFlush      <= 1'b0;
         curPrivileged <= 1'b0;
      end
      else if (clkEn)
      begin
         outValid      <= cmdValid;
         outKind       <= dropCmd ? 5'(batch_privilege_filter_pkg::CMD_NOOP) : cmdKind;
         outMemWrite   <= cmdValid && !dropCmd && memWr;
         outRegWrite   <= cmdValid && !dropCmd && regWr;
         outPostSync   <= cmdValid && postSync;
         outFlush      <= cmdValid &&
                          cmdKind == 5'(batch_privilege_filter_pkg::CMD_PIPE_CONTROL);
         curPrivileged <= privNow;
      end
   end

   assign errSet = {cmdValid && clkEn && condEndErr, cmdValid && clkEn && violation};
   // Sticky error status, set wins over write-one-clear
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         errStatus_q <= 2'h0;
      end
      else if (clkEn)
      begin
         if (apbWrite && paddr == batch_privilege_filter_pkg::OFS_ERR_STATUS)
         begin
            errStatus_q <= (errStatus_q & ~pwdata[1:0]) | errSet;
         end
         else
         begin
            errStatus_q <= errStatus_q | errSet;
         end
      end
   end

   // Error identity: last offending command kind
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         errIdent_q <= 32'h00000000;
      end
      else if (clkEn && (errSet != 2'h0))
      begin
         errIdent_q <= {11'h000, errSet[1], errSet[0], cmdKind, regAddr[13:0]};
      end
   end

   // Software registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         control_q <= batch_privilege_filter_pkg::CONTROL_RESET;
         errMask_q <= batch_privilege_filter_pkg::MASK_RESET;
         for (int i = 0; i < batch_privilege_filter_pkg::LIST_DEPTH; i++)
         begin
            writeList_q[i] <= batch_privilege_filter_pkg::LIST_RESET;
            readList_q[i]  <= batch_privilege_filter_pkg::LIST_RESET;
         end
      end
      else if (apbWrite)
      begin
         if (paddr == batch_privilege_filter_pkg::OFS_CONTROL)
         begin
            control_q <= {29'h0, pwdata[2:0]};
         end
         if (paddr == batch_privilege_filter_pkg::OFS_ERR_MASK)
         begin
            errMask_q <= pwdata[1:0];
         end
         for (int i = 0; i < batch_privilege_filter_pkg::LIST_DEPTH; i++)
         begin
            if (paddr == batch_privilege_filter_pkg::OFS_WLIST_BASE + 12'(4 * i))
            begin
               writeList_q[i] <= pwdata[23:0];
            end
            if (paddr == batch_privilege_filter_pkg::OFS_RLIST_BASE + 12'(4 * i))
            begin
               readList_q[i] <= pwdata[23:0];
            end
         end
      end
   end

   // APB read data and response, one access cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end
      else if (clkEn)
      begin
         irq     <= |((errStatus_q | errSet) & errMask_q);
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable)
         begin
            case (paddr)
               batch_privilege_filter_pkg::OFS_CONTROL:    prdata <= control_q;
               batch_privilege_filter_pkg::OFS_ERR_STATUS: prdata <= {30'h0, errStatus_q};
               batch_privilege_filter_pkg::OFS_ERR_MASK:   prdata <= {30'h0, errMask_q};
               batch_privilege_filter_pkg::OFS_ERR_IDENT:  prdata <= errIdent_q;
               default:
               begin
                  if (paddr[11:5] == 7'h02)
                  begin
                     prdata <= {8'h00, writeList_q[paddr[4:2]]};
                  end
                  else if (paddr[11:5] == 7'h04)
                  begin
                     prdata <= {8'h00, readList_q[paddr[4:2]]};
                  end
                  else
                  begin
                     pslverr <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Checks
   dropNoop_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && cmdValid && dropCmd |=> outKind == 5'(batch_privilege_filter_pkg::CMD_NOOP))
      else $error("dropped command not a no-op");
   violSticky_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && cmdValid && violation |=> errStatus_q[0])
      else $error("violation not recorded");
   disableOk_a: assert property (@(posedge mclk) disable iff (rst)
      checkDisable |-> !dropCmd && !violation)
      else $error("check ran while disabled");
   alwaysNoop_a: assert property (@(posedge mclk) disable iff (rst)
      !privNow && !checkDisable &&
      cmdKind == 5'(batch_privilege_filter_pkg::CMD_DISPLAY_FLIP) |-> dropCmd)
      else $error("flip not dropped");
   srmRead_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && cmdValid && cmdKind == 5'(batch_privilege_filter_pkg::CMD_STORE_REG_TO_MEMORY)
      |=> outKind == 5'(batch_privilege_filter_pkg::CMD_STORE_REG_TO_MEMORY))
      else $error("register read lost");
   flushKept_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && cmdValid && cmdKind == 5'(batch_privilege_filter_pkg::CMD_PIPE_CONTROL)
      |=> outFlush)
      else $error("flush lost");
   copyGlobal_a: assert property (@(posedge mclk) disable iff (rst)
      !privNow && !checkDisable && selGlobalDst &&
      cmdKind == 5'(batch_privilege_filter_pkg::CMD_MEMORY_COPY) |-> dropCmd)
      else $error("global copy not dropped");
   irqLevel_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && $past(clkEn) && |(errStatus_q & errMask_q) |=> irq)
      else $error("interrupt missing");
   childCap_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && cmdValid && !privNow &&
      cmdKind == 5'(batch_privilege_filter_pkg::CMD_BATCH_START) |=> !parentPriv_q)
      else $error("child gained privilege");
   dropSeen_c: cover property (@(posedge mclk) disable iff (rst) clkEn && cmdValid && dropCmd);
   irqSeen_c: cover property (@(posedge mclk) disable iff (rst) irq);
   condEnd_c: cover property (@(posedge mclk) disable iff (rst) clkEn && cmdValid && condEndErr);

endmodule

// file: verif/batch_source_model.sv
`timescale 1ns/1ps
// Command source standing in for software-built batch buffers
module batch_source_model
(
   input  wire logic        mclk,
   output logic             cmdValid,
   output logic [4:0]       cmdKind,
   output logic             bufferGlobal,
   output logic             inRing,
   output logic             selGlobal,
   output logic             selGlobalDst,
   output logic             useStoreIndex,
   output logic             postSyncLoad,
   output logic [23:0]      regAddr,
   output logic [23:0]      regAddrDst
);
   // Quiet bus at time zero
   initial
   begin
      cmdValid = 1'b0;
      {cmdKind, bufferGlobal, inRing, selGlobal, selGlobalDst} = '0;
      {useStoreIndex, postSyncLoad, regAddr, regAddrDst} = '0;
   end

   // One command per call; restricted kinds go to user buffers only on bench request
   task automatic send(input logic [4:0] k, input logic [5:0] f, input logic [23:0] a, b);
      @(posedge mclk);
      cmdValid <= 1'b1;
      cmdKind <= k;
      {bufferGlobal, inRing, selGlobal, selGlobalDst, useStoreIndex, postSyncLoad} <= f;
      regAddr <= a;
      regAddrDst <= b;
      @(posedge mclk);
      // Idle fields show the inverse so stale values never pass
      cmdValid <= 1'b0;
      cmdKind <= ~k;
      {bufferGlobal, inRing, selGlobal, selGlobalDst, useStoreIndex, postSyncLoad} <= ~f;
      regAddr <= ~a;
      regAddrDst <= ~b;
   endtask
endmodule

// file: verif/batch_privilege_filter_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module batch_privilege_filter_tb;
   logic             mclk, rst, clkEn, psel, penable, pwrite;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rdv;
   logic             pready, pslverr, cmdValid, bufferGlobal, inRing, selGlobal, selGlobalDst;
   logic             useStoreIndex, postSyncLoad, outValid, outMemWrite, outRegWrite;
   logic             outPostSync, outFlush, curPrivileged, irq, rerr, parent, dis;
   logic [4:0]       cmdKind, outKind;
   logic [23:0]      regAddr, regAddrDst, ra;
   logic [1:0]       st;
   logic [23:0]      wl [batch_privilege_filter_pkg::LIST_DEPTH];
   logic [23:0]      rl [batch_privilege_filter_pkg::LIST_DEPTH];
   int               err_total, n_tests;

   batch_privilege_filter dut (.mclk(mclk), .rst(rst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cmdValid(cmdValid), .cmdKind(cmdKind),
      .bufferGlobal(bufferGlobal), .inRing(inRing), .selGlobal(selGlobal),
      .selGlobalDst(selGlobalDst), .useStoreIndex(useStoreIndex), .postSyncLoad(postSyncLoad),
      .regAddr(regAddr), .regAddrDst(regAddrDst), .outValid(outValid), .outKind(outKind),
      .outMemWrite(outMemWrite), .outRegWrite(outRegWrite), .outPostSync(outPostSync),
      .outFlush(outFlush), .curPrivileged(curPrivileged), .irq(irq));

   batch_source_model src (.mclk(mclk), .cmdValid(cmdValid), .cmdKind(cmdKind),
      .bufferGlobal(bufferGlobal), .inRing(inRing), .selGlobal(selGlobal),
      .selGlobalDst(selGlobalDst), .useStoreIndex(useStoreIndex), .postSyncLoad(postSyncLoad),
      .regAddr(regAddr), .regAddrDst(regAddrDst));

   // Free-running clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic stop_test();
      $display("Checks %0d, errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // APB transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge mclk);
         if (pready === 1'b1)
            break;
      end
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
      begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, '0);
      `CHK("register", ex, rdv)
      `CHK("slverr", 1'b0, rerr)
   endtask

   task automatic set_ctrl(input logic d, input logic [1:0] s);
      dis = d;
      st = s;
      apb(1'b1, batch_privilege_filter_pkg::OFS_CONTROL, {29'h0, s, d});
   endtask

   function automatic logic [23:0] base_of(input logic [1:0] s);
      return s == 2'h1 ? batch_privilege_filter_pkg::BLITTER_BASE :
             s == 2'h2 ? batch_privilege_filter_pkg::COMPUTE_ZERO_BASE :
             batch_privilege_filter_pkg::RENDER_BASE;
   endfunction

   // Listed offsets match only relative to the selected streamer base
   function automatic logic hit(input logic [23:0] l [batch_privilege_filter_pkg::LIST_DEPTH],
                                input logic [23:0] a);
      logic h;
      h = 1'b0;
      foreach (l[i]) if (l[i] == a - base_of(st)) h = 1'b1;
      return h;
   endfunction

   // Kind that should leave the filter for a command
   function automatic logic [4:0] exp_kind(input logic [4:0] k, input logic pv, sg, sgd, wok,
                                           rok);
      logic [4:0] nop;
      nop = batch_privilege_filter_pkg::CMD_NOOP;
      if (pv)
         return k;
      case (k)
         batch_privilege_filter_pkg::CMD_TRANSLATION_TABLE_UPDATE,
         batch_privilege_filter_pkg::CMD_STORE_BY_INDEX,
         batch_privilege_filter_pkg::CMD_ARBITRATION_TOGGLE,
         batch_privilege_filter_pkg::CMD_DISPLAY_FLIP: return nop;
         batch_privilege_filter_pkg::CMD_CONTEXT_SET:
            return st == batch_privilege_filter_pkg::STREAMER_BLITTER ? k : nop;
         batch_privilege_filter_pkg::CMD_STORE_IMMEDIATE,
         batch_privilege_filter_pkg::CMD_PERF_COUNT_REPORT,
         batch_privilege_filter_pkg::CMD_ATOMIC_MEMORY,
         batch_privilege_filter_pkg::CMD_SEMAPHORE_WAIT,
         batch_privilege_filter_pkg::CMD_CONDITIONAL_BATCH_END: return sg ? nop : k;
         batch_privilege_filter_pkg::CMD_LOAD_REG_FROM_MEMORY:
            return (sg || !wok) ? nop : k;
         batch_privilege_filter_pkg::CMD_LOAD_REG_IMMEDIATE: return wok ? k : nop;
         batch_privilege_filter_pkg::CMD_MEMORY_COPY: return (sg || sgd) ? nop : k;
         batch_privilege_filter_pkg::CMD_REG_READ: return (wok || rok) ? k : nop;
         default: return k;
      endcase
   endfunction

   // Send one command and compare the filtered result; f = {bg, ring, sg, sgd, idx, psl}
   task automatic run_cmd(input logic [4:0] k, input logic [5:0] f, input logic [23:0] a, b);
      logic pv;
      logic ep;
      logic wok;
      pv = f[4] | (f[5] & parent);
      ep = pv | dis;
      wok = hit(wl, a);
      src.send(k, f, a, b);
      #1;
      `CHK("outValid", 1'b1, outValid)
      `CHK("outKind", exp_kind(k, ep, f[3], f[2], wok, hit(rl, a)), outKind)
      if (!dis) `CHK("curPrivileged", pv, curPrivileged)
      if (k == batch_privilege_filter_pkg::CMD_STORE_REG_TO_MEMORY)
         `CHK("outMemWrite", ep | !f[3], outMemWrite)
      if (k == batch_privilege_filter_pkg::CMD_LOAD_REG_FROM_REG)
         `CHK("outRegWrite", ep | hit(wl, b), outRegWrite)
      if (k == batch_privilege_filter_pkg::CMD_PIPE_CONTROL)
      begin
         `CHK("outFlush", 1'b1, outFlush)
         `CHK("outPostSync", f[0] & (ep | !(f[3] | f[1] | !wok)), outPostSync)
      end
      if (k == batch_privilege_filter_pkg::CMD_BATCH_START || f[4])
         parent = pv;
   endtask

   function automatic logic [23:0] pick_addr();
      logic [1:0]  s;
      logic [23:0] o;
      s = ($urandom % 4 == 0) ? 2'($urandom_range(0, 2)) : st;
      case ($urandom % 3)
         0: o = wl[$urandom % 8];
         1: o = rl[$urandom % 8];
         default: o = {12'h000, 10'($urandom), 2'b00};
      endcase
      return base_of(s) + o;
   endfunction

   // Main sequence
   initial
   begin
      {rst, clkEn, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
      {err_total, n_tests, parent, dis, st} = {64'h0, 1'b1, 3'h0};
      void'($urandom(27));
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(batch_privilege_filter_pkg::OFS_CONTROL, batch_privilege_filter_pkg::CONTROL_RESET);
      rd_chk(batch_privilege_filter_pkg::OFS_ERR_STATUS, 32'h0);
      rd_chk(batch_privilege_filter_pkg::OFS_ERR_MASK, {30'h0, batch_privilege_filter_pkg::MASK_RESET});
      rd_chk(batch_privilege_filter_pkg::OFS_WLIST_BASE, {8'h0, batch_privilege_filter_pkg::LIST_RESET});
      apb(1'b0, 12'h0FC, '0);
      `CHK("unmapped", 1'b1, rerr)
      // Program both allow-lists with word-aligned offsets
      for (int i = 0; i < 8; i++)
      begin
         wl[i] = {12'h000, 10'($urandom), 2'b00};
         rl[i] = {12'h000, 10'($urandom), 2'b00};
         apb(1'b1, batch_privilege_filter_pkg::OFS_WLIST_BASE + 12'(4 * i), {8'h0, wl[i]});
         apb(1'b1, batch_privilege_filter_pkg::OFS_RLIST_BASE + 12'(4 * i), {8'h0, rl[i]});
      end
      rd_chk(batch_privilege_filter_pkg::OFS_RLIST_BASE + 12'h01C, {8'h0, rl[7]});
      set_ctrl(1'b0, 2'h0);
      // Violation logged, interrupt raised, masked and cleared
      ra = batch_privilege_filter_pkg::RENDER_BASE + 24'h000FFE;
      apb(1'b1, batch_privilege_filter_pkg::OFS_ERR_MASK, 32'h3);
      run_cmd(batch_privilege_filter_pkg::CMD_LOAD_REG_IMMEDIATE, 6'h00, ra, ra);
      rd_chk(batch_privilege_filter_pkg::OFS_ERR_STATUS, 32'h1);
      apb(1'b0, batch_privilege_filter_pkg::OFS_ERR_IDENT, '0);
      `CHK("ident", {2'b01, batch_privilege_filter_pkg::CMD_LOAD_REG_IMMEDIATE, ra[13:0]}, rdv[20:0])
      `CHK("irq", 1'b1, irq)
      apb(1'b1, batch_privilege_filter_pkg::OFS_ERR_MASK, 32'h0);
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b0, irq)
      apb(1'b1, batch_privilege_filter_pkg::OFS_ERR_STATUS, 32'h1);
      apb(1'b1, batch_privilege_filter_pkg::OFS_ERR_MASK, 32'h3);
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b0, irq)
      clkEn <= 1'b0;
      src.send(batch_privilege_filter_pkg::CMD_DISPLAY_FLIP, 6'h00, ra, ra);
      clkEn <= 1'b1;
      #1 `CHK("frozen", 1'b0, outValid)
      // Conditional end under global selection in a user buffer
      run_cmd(batch_privilege_filter_pkg::CMD_CONDITIONAL_BATCH_END, 6'h08, ra, ra);
      apb(1'b0, batch_privilege_filter_pkg::OFS_ERR_STATUS, '0);
      `CHK("condEnd", 1'b1, rdv[1])
      apb(1'b1, batch_privilege_filter_pkg::OFS_ERR_STATUS, 32'h3);
      // Checks disabled: privileged load passes
      set_ctrl(1'b1, 2'h0);
      run_cmd(batch_privilege_filter_pkg::CMD_LOAD_REG_IMMEDIATE, 6'h00, ra, ra);
      set_ctrl(1'b0, 2'h1);
      // Chained buffer from a user buffer cannot gain privilege
      run_cmd(batch_privilege_filter_pkg::CMD_BATCH_START, 6'h00, ra, ra);
      run_cmd(batch_privilege_filter_pkg::CMD_TRANSLATION_TABLE_UPDATE, 6'h20, ra, ra);
      run_cmd(batch_privilege_filter_pkg::CMD_BATCH_START, 6'h10, ra, ra);
      // Every kind once in a user buffer with global selection
      for (int k = 0; k < 20; k++)
         run_cmd(5'(k), 6'h08, pick_addr(), pick_addr());
      // Random traffic across streamers and check-disable settings
      for (int blk = 0; blk < 6; blk++)
      begin
         set_ctrl($urandom % 4 == 0, 2'($urandom_range(0, 2)));
         for (int n = 0; n < 40; n++)
            run_cmd(5'($urandom_range(0, 19)), {6'($urandom) & 6'h2F} | {1'b0, $urandom % 4 == 0,
                    4'h0}, pick_addr(), pick_addr());
      end
      stop_test();
   end
endmodule
